// file: design/irq_seq_pkg.sv
// Shared constants, types and helpers of the interrupt service sequencer
package irq_seq_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NIRQ = 64;
   localparam int AW   = 10;
   localparam int DW   = 32;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [9:0] OFS_LATCH  = 10'h000;
   localparam logic [9:0] OFS_SET    = 10'h008;
   localparam logic [9:0] OFS_CLR    = 10'h010;
   localparam logic [9:0] OFS_MASK   = 10'h018;
   localparam logic [9:0] OFS_PRIO   = 10'h020;
   localparam logic [9:0] OFS_SENS   = 10'h028;
   localparam logic [9:0] OFS_CTRL   = 10'h030;
   localparam logic [9:0] OFS_HWRET  = 10'h038;
   localparam logic [9:0] OFS_ALIAS  = 10'h03C;
   localparam logic [9:0] OFS_SWRET  = 10'h040;
   localparam logic [9:0] OFS_DBGRET = 10'h044;
   localparam logic [9:0] OFS_VEC    = 10'h200;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int GIE_BIT      = 2;
   localparam int EXC_FLAG_BIT = 21;
   localparam int EMU_FLAG_BIT = 22;
   localparam logic [5:0]  SW_IDX    = 6'h3E;
   localparam logic [5:0]  DBG_IDX   = 6'h3F;
   localparam logic [63:0] ONE64     = 64'h0000_0000_0000_0001;
   localparam logic [63:0] HW_ONLY   = 64'h3FFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] SENS_RST  = 64'hFDFF_FFFF_FFFF_FC3F;
   localparam logic [63:0] MASK_RST  = 64'h0000_0000_0000_0000;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] VEC_RST   = 32'h0000_0000;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_USER, MODE_SUPER, MODE_EMU} cpu_mode_t;
   typedef enum logic [0:0] {S_IDLE, S_FLIGHT} seq_state_t;
   typedef struct packed {
      logic        redirect;
      logic        flush;
      logic [31:0] addr;
   } fetch_cmd_t;
   typedef struct packed {
      logic        valid;
      logic        emu;
      logic        killed;
      logic [31:0] pc;
   } exc_req_t;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [5:0] msb_index(input logic [63:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < NIRQ; i++)
         if (v[i])
            r = 6'(i);
      return r;
   endfunction
   function automatic logic [31:0] sel_mask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction
   function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] d,
                                           input logic [31:0] m);
      return (old & ~m) | (d & m);
   endfunction
endpackage

// file: design/msb_finder.sv
// Highest set bit of a 64-bit vector and the mask of bits above it
`timescale 1ns/1ps
module msb_finder
   import irq_seq_pkg::*;
(
   input  wire logic [63:0] vec_i,
   output logic      [5:0]  idx_o,
   output logic             any_o,
   output logic      [63:0] above_o
);
   logic [63:0] upto;

   // Priority follows bit position, bit zero lowest
   assign idx_o = msb_index(vec_i);
   assign any_o = |vec_i;
   // Ones from bit zero up to and including the top set bit
   assign upto    = ((ONE64 << idx_o) << 1) - ONE64;
   // All ones when nothing is set
   assign above_o = any_o ? ~upto : ~MASK_RST;
endmodule

// file: design/vector_table.sv
// Table of service routine start addresses, one per interrupt
`timescale 1ns/1ps
module vector_table
   import irq_seq_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        we_i,
   input  wire logic [5:0]  widx_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [31:0] wmask_i,
   input  wire logic [5:0]  bus_idx_i,
   output logic      [31:0] bus_data_o,
   input  wire logic [5:0]  svc_idx_i,
   output logic      [31:0] svc_data_o
);
   logic [31:0] vec [NIRQ];

   // Vectors clear at reset so a boot routine can sit at zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < NIRQ; i++)
            vec[i] <= VEC_RST;
      end
      else if (we_i)
      begin
         vec[widx_i] <= merge32(vec[widx_i], wdata_i, wmask_i);
      end
   end

   // Two read ports: bus and service
   assign bus_data_o = vec[bus_idx_i];
   assign svc_data_o = vec[svc_idx_i];
endmodule

// file: design/irq_service_seq.sv
// Interrupt service sequencer: selection, entry, abort and return
//
// What this block does
// - Service top pending bit of latch AND enable AND block mask when enabled.
// - Accepted interrupt redirects fetch to its table vector.
// - Hardware entry keeps pipeline running; exceptions flush it.
// - Interrupt in flight blocks other hardware interrupts, masks untouched.
// - Disabled exceptions are dropped, never latched.
// - Recheck global enable at stage two; if clear, flush and resume.
// - Return address goes to hardware, software or debug register.
// - Entry switches to emulation mode for debug, else supervisor.
// - At stage two clear edge latch bit, set active priority bit.
// - Hardware return register written on successful stage-two entry or by a bus write to it or its alias.
// - Enabled exception aborts hardware routine in flight; latch stays set.
// - Exceptions ignore the global hardware enable.
// - Reading the return alias re-enables nesting.
// - Writing the return alias blocks interrupts until return.
// - Return clears top active bit, jumps to return register, re-enables.
// - Exception sets flag 21 or 22, vectors, saves PC, flushes.
// - Killed speculative exceptions vanish; false predicates still raise.
// - Higher bit positions take precedence, bit zero lowest.
// - Block mask sets bits above top active bit; all ones if idle.
// - Global hardware enable is control bit 2.
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
module irq_service_seq
   import irq_seq_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [DW-1:0] wb_dat_i,
   output logic      [DW-1:0] wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic [63:0]   irq_i,
   input  wire logic          ex2_first_i,
   input  wire logic [31:0]   ex2_ret_pc_i,
   input  wire exc_req_t      exc_i,
   input  wire logic          rti_i,
   output fetch_cmd_t         fetch_o,
   output cpu_mode_t          mode_o,
   output logic               hw_flight_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   seq_state_t  state;
   logic [63:0] latch;
   logic [63:0] next_latch;
   logic [63:0] mask;
   logic [63:0] prio;
   logic [63:0] next_prio;
   logic [63:0] sens;
   logic [63:0] irq_q;
   logic [31:0] ctrl;
   logic [31:0] hw_ret;
   logic [31:0] sw_ret;
   logic [31:0] dbg_ret;
   logic [5:0]  cur_idx;
   logic        nest_block;
   logic        alias_lock;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   logic        acc;
   logic        fire;
   logic        wr;
   logic        rd;
   logic        hi;
   logic [9:0]  pair;
   logic [31:0] wm;
   logic [31:0] wd;
   logic [63:0] wd64;
   logic [63:0] wm64;
   logic [31:0] bus_vec;

   assign acc  = wb_cyc_i & wb_stb_i;
   // Effects land on the edge where the master sees ack
   assign fire = acc & wb_ack_o;
   assign wr   = fire & wb_we_i;
   assign rd   = fire & ~wb_we_i;
   assign hi   = wb_adr_i[2];
   assign pair = {wb_adr_i[9:3], 3'b000};
   assign wm   = sel_mask(wb_sel_i);
   assign wd   = wb_dat_i;
   assign wd64 = hi ? {wd, 32'h0000_0000} : {32'h0000_0000, wd};
   assign wm64 = hi ? {wm, 32'h0000_0000} : {32'h0000_0000, wm};

   // One wait state, ack drops after one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= acc & ~wb_ack_o;
   end

   // Write strobes per register
   logic w_set;
   logic w_clr;
   logic w_mask;
   logic w_prio;
   logic w_sens;
   logic w_ctrl;
   logic w_hwret;
   logic w_alias;
   logic w_vec;
   logic r_alias;

   assign w_set   = wr & (pair == OFS_SET);
   assign w_clr   = wr & (pair == OFS_CLR);
   assign w_mask  = wr & (pair == OFS_MASK);
   assign w_prio  = wr & (pair == OFS_PRIO);
   assign w_sens  = wr & (pair == OFS_SENS);
   assign w_ctrl  = wr & (wb_adr_i == OFS_CTRL);
   assign w_hwret = wr & (wb_adr_i == OFS_HWRET);
   assign w_alias = wr & (wb_adr_i == OFS_ALIAS);
   assign w_vec   = wr & wb_adr_i[9];
   assign r_alias = rd & (wb_adr_i == OFS_ALIAS);

   // Read mux, unmapped reads return zero
   logic [31:0] rmux;
   always_comb
   begin
      rmux = 32'h0000_0000;
      if (wb_adr_i[9])
         rmux = bus_vec;
      else
      begin
         case (pair)
            OFS_LATCH: rmux = hi ? latch[63:32] : latch[31:0];
            OFS_MASK:  rmux = hi ? mask[63:32] : mask[31:0];
            OFS_PRIO:  rmux = hi ? prio[63:32] : prio[31:0];
            OFS_SENS:  rmux = hi ? sens[63:32] : sens[31:0];
            OFS_CTRL:  rmux = hi ? 32'h0000_0000 : ctrl;
            OFS_HWRET: rmux = hw_ret;
            OFS_SWRET: rmux = hi ? dbg_ret : sw_ret;
            default:   rmux = 32'h0000_0000;
         endcase
      end
   end

   // Read data captured in the request cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (acc & ~wb_ack_o & ~wb_we_i)
         wb_dat_o <= rmux;
   end

   // ----------------------------------------
   // Priority selection
   // ----------------------------------------
   logic [63:0] pend;
   logic [63:0] block_mask;
   logic [5:0]  pidx;
   logic [5:0]  aidx;
   logic        pany;
   logic        aany;
   logic        global_hw_irq_enable;
   logic        hw_block;
   logic        accept;
   logic        exc_take;
   logic        exc_en;
   logic        entry_ok;
   logic        entry_fail;
   logic        swi_abort;
   logic [5:0]  svc_idx;
   logic [31:0] svc_vec;
   logic [63:0] src_rise;

   assign global_hw_irq_enable      = ctrl[GIE_BIT];
   // Blocked while in flight, not nested, or alias written
   assign hw_block = (state == S_FLIGHT) | nest_block | alias_lock;
   assign pend     = latch & mask & block_mask & HW_ONLY;

   msb_finder u_pend (
      .vec_i   (pend),
      .idx_o   (pidx),
      .any_o   (pany),
      .above_o ()
   );

   msb_finder u_act (
      .vec_i   (prio),
      .idx_o   (aidx),
      .any_o   (aany),
      .above_o (block_mask)
   );

   // Exceptions need only their own enable, never the global one
   assign exc_en   = exc_i.emu ? mask[DBG_IDX] : mask[SW_IDX];
   assign exc_take = exc_i.valid & ~exc_i.killed & exc_en;
   // Top enabled pending interrupt is taken
   assign accept   = (state == S_IDLE) & global_hw_irq_enable & ~hw_block & pany
                     & ~exc_take & ~rti_i;
   assign entry_ok   = (state == S_FLIGHT) & ex2_first_i & global_hw_irq_enable & ~exc_take;
   assign entry_fail = (state == S_FLIGHT) & ex2_first_i & ~global_hw_irq_enable & ~exc_take;
   assign swi_abort  = (state == S_FLIGHT) & exc_take;
   assign svc_idx  = exc_take ? (exc_i.emu ? DBG_IDX : SW_IDX) : pidx;
   assign src_rise = irq_i & ~irq_q;
   assign hw_flight_o = (state == S_FLIGHT);

   vector_table u_vec (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .we_i       (w_vec),
      .widx_i     (wb_adr_i[7:2]),
      .wdata_i    (wd),
      .wmask_i    (wm),
      .bus_idx_i  (wb_adr_i[7:2]),
      .bus_data_o (bus_vec),
      .svc_idx_i  (svc_idx),
      .svc_data_o (svc_vec)
   );

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   // Flight tracking from vector insertion to stage two
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state   <= S_IDLE;
         cur_idx <= 6'h00;
      end
      else
      begin
         case (state)
            S_IDLE:
            begin
               if (accept)
               begin
                  state   <= S_FLIGHT;
                  cur_idx <= pidx;
               end
            end
            S_FLIGHT:
            begin
               if (swi_abort)
                  state <= S_IDLE;
               else if (ex2_first_i)
                  state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Source edge history
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_q <= MASK_RST;
      else
         irq_q <= irq_i;
   end

   // Latch: bus set and clear, entry clear, source set wins
   always_comb
   begin
      next_latch = latch;
      if (w_set)
         next_latch = next_latch | (wd64 & wm64);
      if (w_clr)
         next_latch = next_latch & ~(~wd64 & wm64);
      if (entry_ok)
         next_latch[cur_idx] = 1'b0;
      next_latch = next_latch | (src_rise & sens);
      // Level sources are followed as they are
      next_latch = (next_latch & sens) | (irq_i & ~sens);
      next_latch = next_latch & HW_ONLY;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         latch <= MASK_RST;
      else
         latch <= next_latch;
   end

   // Active priority: return clears top bit, entries set theirs
   always_comb
   begin
      next_prio = prio;
      if (w_prio)
         next_prio = (next_prio & ~wm64) | (wd64 & wm64);
      if (rti_i & aany)
         next_prio[aidx] = 1'b0;
      if (entry_ok)
         next_prio[cur_idx] = 1'b1;
      if (exc_take)
         next_prio[svc_idx] = 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         prio <= MASK_RST;
      else
         prio <= next_prio;
   end

   // Enable mask and sensitivity
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mask <= MASK_RST;
         sens <= SENS_RST;
      end
      else
      begin
         if (w_mask)
            mask <= (mask & ~wm64) | (wd64 & wm64);
         if (w_sens)
            sens <= (sens & ~wm64) | (wd64 & wm64);
      end
   end

   // Control word over the bus, exception flags set by a taken exception
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl <= CTRL_RST;
      else
      begin
         ctrl <= w_ctrl ? merge32(ctrl, wd, wm) : ctrl;
         if (exc_take & ~exc_i.emu)
            ctrl[EXC_FLAG_BIT] <= 1'b1;
         if (exc_take & exc_i.emu)
            ctrl[EMU_FLAG_BIT] <= 1'b1;
      end
   end

   // Return registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hw_ret  <= 32'h0000_0000;
         sw_ret  <= 32'h0000_0000;
         dbg_ret <= 32'h0000_0000;
      end
      else
      begin
         if (entry_ok)
            hw_ret <= ex2_ret_pc_i;
         else if (w_hwret | w_alias)
            hw_ret <= merge32(hw_ret, wd, wm);
         if (exc_take & ~exc_i.emu)
            sw_ret <= exc_i.pc;
         if (exc_take & exc_i.emu)
            dbg_ret <= exc_i.pc;
      end
   end

   // Nesting stays off until the alias is read out or a return comes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         nest_block <= 1'b0;
      else if (entry_ok)
         nest_block <= 1'b1;
      else if (r_alias | rti_i)
         nest_block <= 1'b0;
   end

   // Alias write guards the return register until return
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         alias_lock <= 1'b0;
      else if (w_alias)
         alias_lock <= 1'b1;
      else if (rti_i)
         alias_lock <= 1'b0;
   end

   // Processor mode
   logic [63:0] prio_left;
   assign prio_left = prio & ~(ONE64 << aidx);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode_o <= MODE_SUPER;
      else if (exc_take)
         mode_o <= exc_i.emu ? MODE_EMU : MODE_SUPER;
      else if (entry_ok)
         mode_o <= MODE_SUPER;
      else if (rti_i)
      begin
         if (prio_left[DBG_IDX])
            mode_o <= MODE_EMU;
         else if (|prio_left)
            mode_o <= MODE_SUPER;
         else
            mode_o <= MODE_USER;
      end
   end

   // Fetch redirection commands, one-cycle pulses
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fetch_o <= '0;
      else
      begin
         fetch_o.redirect <= 1'b0;
         fetch_o.flush    <= 1'b0;
         if (exc_take)
         begin
            fetch_o.redirect <= 1'b1;
            fetch_o.flush    <= 1'b1;
            fetch_o.addr     <= svc_vec;
         end
         else if (accept)
         begin
            fetch_o.redirect <= 1'b1;
            fetch_o.addr     <= svc_vec;
         end
         else if (entry_fail)
         begin
            fetch_o.redirect <= 1'b1;
            fetch_o.flush    <= 1'b1;
            fetch_o.addr     <= ex2_ret_pc_i;
         end
         else if (rti_i)
         begin
            fetch_o.redirect <= 1'b1;
            fetch_o.flush    <= 1'b1;
            fetch_o.addr     <= hw_ret;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   hw_vector_fetch_a: assert property (accept |=> fetch_o.redirect && !fetch_o.flush
      && fetch_o.addr == $past(svc_vec) && hw_flight_o) else $error("bad hw vector fetch");
   flight_holds_a: assert property (state == S_FLIGHT && !ex2_first_i && !exc_take
      |=> state == S_FLIGHT && $stable(cur_idx)) else $error("flight disturbed");
   recheck_abort_a: assert property (entry_fail && sens[cur_idx] && !w_clr
      |=> fetch_o.flush && latch[$past(cur_idx)] && !prio[$past(cur_idx)]) else $error("recheck");
   entry_marks_a: assert property (entry_ok && sens[cur_idx] && !src_rise[cur_idx] && !w_set && !w_prio
      |=> !latch[$past(cur_idx)] && prio[$past(cur_idx)]) else $error("entry marks");
   hw_ret_save_a: assert property (entry_ok |=> hw_ret == $past(ex2_ret_pc_i)
      ##1 nest_block || $past(r_alias) || $past(rti_i)) else $error("hw ret");
   exc_drop_a: assert property (exc_i.valid && !exc_take |=> $stable(sw_ret) && $stable(dbg_ret)
      && latch[63:62] == 2'b00) else $error("disabled exc acted");
   exc_entry_a: assert property (exc_take && !exc_i.emu |=> ctrl[EXC_FLAG_BIT]
      && sw_ret == $past(exc_i.pc) && mode_o == MODE_SUPER && fetch_o.flush) else $error("exc");
   swi_abort_a: assert property (swi_abort && sens[cur_idx] && !w_clr
      |=> state == S_IDLE && latch[$past(cur_idx)]) else $error("abort lost");
   rti_return_a: assert property (rti_i && aany && !entry_ok && !exc_take && !w_prio && !w_alias
      |=> !prio[$past(aidx)] && fetch_o.addr == $past(hw_ret) && !alias_lock) else $error("rti");
endmodule

// file: testbench/pipe_model.sv
// Fetch pipeline partner: brings the first routine line to stage two
`timescale 1ns/1ps
module pipe_model
   import irq_seq_pkg::*;
#(
   parameter logic [31:0] RET_PC = 32'h0000_0100
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire fetch_cmd_t fetch_i,
   input  wire logic [3:0] dly_i,
   output logic            ex2_first_o,
   output logic [31:0]     ret_pc_o
);
   logic [4:0] cnt;
   logic       tog;
   // Entry travels dly_i + 1 cycles from the redirect pulse; any flush kills it
   always_ff @(posedge clk_i)
   begin
      if (rst_i || fetch_i.flush)
         cnt <= 5'h00;
      else if (fetch_i.redirect)
         cnt <= {1'b0, dly_i} + 5'h01;
      else if (cnt != 5'h00)
         cnt <= cnt - 5'h01;
   end
   // Pattern keeps the return PC meaningless outside the pulse
   always_ff @(posedge clk_i)
      tog <= rst_i ? 1'b0 : ~tog;
   assign ex2_first_o = (cnt == 5'h01);
   assign ret_pc_o = ex2_first_o ? RET_PC : {32{tog}};
endmodule

// file: testbench/tb_top.sv
// Self-checking bench of the interrupt service sequencer
`timescale 1ns/1ps
module tb_top
   import irq_seq_pkg::*;
;
   // ----------------------------------------
   // Stimulus and wiring
   // ----------------------------------------
   localparam logic [31:0] RPC = 32'h0000_0100;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       cyc = 1'b0;
   logic       stb = 1'b0;
   logic       we = 1'b0;
   logic       return_from_interrupt = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] wdo;
   logic [31:0] rpc;
   logic [63:0] irq = 64'h0000_0000_0000_0000;
   logic [3:0] dly = 4'h2;
   logic [3:0] sel = 4'h0;
   exc_req_t   exc = '0;
   logic       ack;
   logic       ex2;
   logic       fl;
   fetch_cmd_t fo;
   cpu_mode_t  mode;
   int         errors = 0;
   int         cmp_count = 0;
   always #12.5 clk_i = ~clk_i;
   irq_service_seq irq_service_seq_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wdo), .wb_ack_o(ack), .irq_i(irq), .ex2_first_i(ex2), .ex2_ret_pc_i(rpc),
      .exc_i(exc), .rti_i(return_from_interrupt), .fetch_o(fo), .mode_o(mode), .hw_flight_o(fl));
   pipe_model #(.RET_PC(RPC)) pipe_model_i (.clk_i(clk_i), .rst_i(rst_i), .fetch_i(fo),
      .dly_i(dly), .ex2_first_o(ex2), .ret_pc_o(rpc));
   // ----------------------------------------
   // Bus, pipeline and compare helpers
   // ----------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = wdo;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task rd(input logic [9:0] a, input string n, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(n, e, rdat);
   endtask
   task redir(input logic [31:0] a, input logic f);
      do @(posedge clk_i); while (fo.redirect !== 1'b1);
      chk("fetch addr", a, fo.addr);
      chk("fetch flush", {31'h0000_0000, f}, {31'h0000_0000, fo.flush});
   endtask
   task settle;
      while (fl !== 1'b0)
         @(posedge clk_i);
      @(posedge clk_i);
   endtask
   task rti_pulse;
      @(posedge clk_i);
      return_from_interrupt <= 1'b1;
      @(posedge clk_i);
      return_from_interrupt <= 1'b0;
   endtask
   task exc_pulse(input logic e, input logic k, input logic [31:0] pc);
      @(posedge clk_i);
      exc <= '{1'b1, e, k, pc};
      @(posedge clk_i);
      exc <= '0;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      rd(OFS_SENS, "sens low", 32'hFFFF_FC3F);
      rd(OFS_CTRL, "ctrl", 32'h0000_0000);
      rd(10'h100, "unmapped", 32'h0000_0000);
      chk("mode", 32'h0000_0001, {30'h0000_0000, mode});
   endtask
   task t_nest;
      bus(1'b1, 10'h214, 32'h0000_1400);
      bus(1'b1, 10'h20C, 32'h0000_0C00);
      bus(1'b1, OFS_MASK, 32'h0000_0028);
      bus(1'b1, OFS_CTRL, 32'h0000_0004);
      @(posedge clk_i);
      irq <= 64'h0000_0000_0000_0028;
      redir(32'h0000_1400, 1'b0);
      irq <= 64'h0000_0000_0000_0000;
      settle;
      rd(OFS_PRIO, "prio", 32'h0000_0020);
      rd(OFS_LATCH, "latch", 32'h0000_0008);
      rd(OFS_HWRET, "hw ret", RPC);
      rti_pulse;
      redir(RPC, 1'b1);
      redir(32'h0000_0C00, 1'b0);
      settle;
      chk("mode", 32'h0000_0001, {30'h0000_0000, mode});
      rd(OFS_PRIO, "prio", 32'h0000_0008);
      rti_pulse;
      redir(RPC, 1'b1);
   endtask
   task t_recheck;
      dly <= 4'hC;
      irq <= 64'h0000_0000_0000_0020;
      redir(32'h0000_1400, 1'b0);
      bus(1'b1, OFS_CTRL, 32'h0000_0000);
      redir(RPC, 1'b1);
      irq <= 64'h0000_0000_0000_0000;
      rd(OFS_LATCH, "latch", 32'h0000_0020);
      rd(OFS_PRIO, "prio", 32'h0000_0000);
   endtask
   task t_alias;
      dly <= 4'h2;
      bus(1'b1, 10'h238, 32'h0000_3800);
      bus(1'b1, OFS_MASK, 32'h0000_C028);
      bus(1'b1, OFS_CTRL, 32'h0000_0004);
      redir(32'h0000_1400, 1'b0);
      chk("hw flight", 32'h0000_0001, {31'h0000_0000, fl});
      settle;
      irq <= 64'h0000_0000_0000_4000;
      repeat (4) @(posedge clk_i);
      chk("hw flight", 32'h0000_0000, {31'h0000_0000, fl});
      rd(OFS_LATCH, "latch", 32'h0000_4000);
      rd(OFS_ALIAS, "alias", RPC);
      redir(32'h0000_3800, 1'b0);
      settle;
      bus(1'b1, OFS_ALIAS, 32'h0000_0700);
      rd(OFS_ALIAS, "alias", 32'h0000_0700);
      irq <= 64'h0000_0000_0000_8000;
      repeat (8) @(posedge clk_i);
      chk("hw flight", 32'h0000_0000, {31'h0000_0000, fl});
      rti_pulse;
      redir(32'h0000_0700, 1'b1);
      redir(32'h0000_0000, 1'b0);
      settle;
      repeat (2)
      begin
         rti_pulse;
         redir(RPC, 1'b1);
      end
      dly <= 4'hC;
      bus(1'b1, 10'h01C, 32'h4000_0000);
      irq <= 64'h0000_0000_0000_4000;
      redir(32'h0000_3800, 1'b0);
      exc_pulse(1'b0, 1'b0, 32'h0000_0A00);
      redir(32'h0000_0000, 1'b1);
      chk("hw flight", 32'h0000_0000, {31'h0000_0000, fl});
      rd(OFS_LATCH, "latch", 32'h0000_4000);
      bus(1'b1, 10'h01C, 32'h0000_0000);
      bus(1'b1, OFS_CTRL, 32'h0000_0000);
   endtask
   task t_exc;
      bus(1'b1, 10'h2F8, 32'h0000_6200);
      bus(1'b1, 10'h2FC, 32'h0000_6300);
      exc_pulse(1'b0, 1'b0, 32'h0000_0500);
      bus(1'b1, 10'h01C, 32'hC000_0000);
      exc_pulse(1'b0, 1'b1, 32'h0000_0500);
      rd(OFS_CTRL, "ctrl", 32'h0000_0000);
      exc_pulse(1'b0, 1'b0, 32'h0000_0500);
      redir(32'h0000_6200, 1'b1);
      rd(OFS_CTRL, "ctrl", 32'h0020_0000);
      rd(OFS_SWRET, "sw ret", 32'h0000_0500);
      chk("mode", 32'h0000_0001, {30'h0000_0000, mode});
      bus(1'b1, OFS_HWRET, rdat);
      rti_pulse;
      redir(32'h0000_0500, 1'b1);
      exc_pulse(1'b1, 1'b0, 32'h0000_0600);
      redir(32'h0000_6300, 1'b1);
      rd(OFS_DBGRET, "dbg ret", 32'h0000_0600);
      chk("mode", 32'h0000_0002, {30'h0000_0000, mode});
   endtask
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task results;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_nest;
      t_recheck;
      t_alias;
      t_exc;
      results;
   end
   // Watchdog well beyond the few hundred cycles of the run
   initial
   begin
      repeat (5000) @(posedge clk_i);
      errors++;
      results;
   end
endmodule
